// ===== rtl/cfg_port_pkg.sv
// Constants shared by both ends of the three-wire configuration port.
// Assumes both ends run on one system clock and sample the link pins through synchronisers.
// How it works
// - Chip select low gates every cycle
// - Frame starts first rise after select falls
// - Select held low streams successive bytes
// - Select may rise between bytes, transfer resumes
// - Select high releases data pin, alternate function
// - Data counted in eight-bit words
// - First instruction bit selects read or write, last instruction bit when least first
// - Read turns data pin to output
// - Most significant first, least first selectable
// - Pin input in writes, output in readback
// - Host drives shift clock and select
// - Host keeps port idle when quiet needed
// - Shift clock times every bit
package cfg_port_pkg;
   // ----------------------------------------
   // Sizes and timing
   // ----------------------------------------
   localparam int WORD_BITS = 8;
   localparam int ADDR_BITS = 15;
   localparam int INSTR_BITS = 16;
   localparam int CLOCK_NS = 50;
   localparam int SCLK_PERIOD_NS = 400;
   localparam int SCLK_HALF_CYCLES = (SCLK_PERIOD_NS / 2) / CLOCK_NS;
   // Select-high gap limit; a gap of this many cycles less one or more closes a frame, shorter gaps are byte stalls
   localparam int STALL_LIMIT_CYCLES = 8;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [2:0] BIT_CNT_RESET = 3'h0;
   localparam logic [4:0] PHASE_RESET = 5'h00;
endpackage

// ===== rtl/cfg_port_if.sv
// Three-wire link between host and converter configuration port.
// Assumes the bench resolves the shared data wire from the two enables.
interface cfg_port_if;
   logic sclk;
   logic chip_select_n;
   logic sdio_host_o;
   logic sdio_host_oe;
   logic sdio_dev_o;
   logic sdio_dev_oe;
   logic sdio;
   modport host(output sclk, output chip_select_n, output sdio_host_o, output sdio_host_oe, input sdio);
   modport device(input sclk, input chip_select_n, output sdio_dev_o, output sdio_dev_oe, input sdio);
endinterface

// ===== rtl/cfg_port_device.sv
// Device end of the configuration port: instruction decode, write strobes, readback shift.
// Assumes link pins are asynchronous; a user-side register store answers reads in one cycle.
module cfg_port_device (
   input wire logic clock,
   input wire logic rst,
   cfg_port_if.device link,
   input wire logic lsb_first,
   output logic [14:0] reg_addr,
   output logic [7:0] wr_data,
   output logic wr_strobe,
   input wire logic [7:0] rd_data,
   output logic rd_strobe,
   output logic port_idle
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [1:0] sclk_sync_reg, cs_sync_reg, sdio_sync_reg;
   logic sclk_d_reg, cs_d_reg;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sclk_sync_reg <= 2'h0;
         cs_sync_reg <= 2'h3;
         sdio_sync_reg <= 2'h0;
         sclk_d_reg <= 1'b0;
         cs_d_reg <= 1'b1;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[0], link.sclk};
         cs_sync_reg <= {cs_sync_reg[0], link.chip_select_n};
         sdio_sync_reg <= {sdio_sync_reg[0], link.sdio};
         sclk_d_reg <= sclk_sync_reg[1];
         cs_d_reg <= cs_sync_reg[1];
      end
   end
   logic cs_low, sclk_rise, sclk_fall, cs_fall, sdi;
   assign cs_low = ~cs_sync_reg[1];
   assign sclk_rise = cs_low & sclk_sync_reg[1] & ~sclk_d_reg;
   assign sclk_fall = cs_low & ~sclk_sync_reg[1] & sclk_d_reg;
   assign cs_fall = cs_d_reg & ~cs_sync_reg[1];
   assign sdi = sdio_sync_reg[1];

   // ----------------------------------------
   // Frame state
   // ----------------------------------------
   typedef enum {ST_IDLE, ST_INSTR, ST_WRITE, ST_READ} phase_t;
   phase_t phase_reg;
   logic [4:0] bit_cnt_reg;
   logic [15:0] shift_reg;
   logic [7:0] tx_reg;
   logic in_frame_reg, load_pending_reg;
   logic tx_loaded_reg;
   logic [4:0] last_bit;
   assign last_bit = (phase_reg == ST_INSTR) ? 5'h0F : 5'h07;

   // ----------------------------------------
   // Stall timer
   // ----------------------------------------
   // A select held high for the limit less one cycle or longer closes the frame, so the next fall starts a new one
   logic [3:0] stall_cnt_reg;
   logic stall_over;
   assign stall_over = stall_cnt_reg == 4'(cfg_port_pkg::STALL_LIMIT_CYCLES - 1);
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         stall_cnt_reg <= 4'h0;
      else if (cs_low || !in_frame_reg)
         stall_cnt_reg <= 4'h0;
      else if (!stall_over)
         stall_cnt_reg <= stall_cnt_reg + 4'h1;
   end

   // Incoming bit placed by bit order for data bytes
   logic [7:0] byte_next;
   always_comb begin
      byte_next = shift_reg[7:0];
      if (lsb_first)
         byte_next = {sdi, shift_reg[7:1]};
      else
         byte_next = {shift_reg[6:0], sdi};
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         phase_reg <= ST_IDLE;
         bit_cnt_reg <= cfg_port_pkg::PHASE_RESET;
         shift_reg <= 16'h0000;
         in_frame_reg <= 1'b0;
         reg_addr <= 15'h0000;
         wr_data <= cfg_port_pkg::REG_RESET;
         wr_strobe <= 1'b0;
         rd_strobe <= 1'b0;
      end else begin
         wr_strobe <= 1'b0;
         rd_strobe <= 1'b0;
         if (cs_fall && !in_frame_reg) begin
            phase_reg <= ST_INSTR;
            bit_cnt_reg <= cfg_port_pkg::PHASE_RESET;
            in_frame_reg <= 1'b1;
         end else if (stall_over) begin
            phase_reg <= ST_IDLE;
            in_frame_reg <= 1'b0;
         end else if (sclk_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (phase_reg == ST_INSTR) begin
               shift_reg <= lsb_first ? {sdi, shift_reg[15:1]} : {shift_reg[14:0], sdi};
               if (bit_cnt_reg == last_bit) begin
                  bit_cnt_reg <= cfg_port_pkg::PHASE_RESET;
                  if (lsb_first) begin
                     reg_addr <= shift_reg[15:1];
                     phase_reg <= sdi ? ST_READ : ST_WRITE;
                     rd_strobe <= sdi;
                  end else begin
                     reg_addr <= {shift_reg[13:0], sdi};
                     phase_reg <= shift_reg[14] ? ST_READ : ST_WRITE;
                     rd_strobe <= shift_reg[14];
                  end
               end
            end else begin
               shift_reg[7:0] <= byte_next;
               if (bit_cnt_reg == last_bit) begin
                  bit_cnt_reg <= cfg_port_pkg::PHASE_RESET;
                  if (phase_reg == ST_WRITE) begin
                     wr_data <= byte_next;
                     wr_strobe <= 1'b1;
                  end else begin
                     // Advance with the strobe so the store answers the next address
                     rd_strobe <= 1'b1;
                     reg_addr <= reg_addr + 15'h0001;
                  end
               end
            end
         end
         // Completed write advances the address once the store has taken it
         if (wr_strobe && phase_reg == ST_WRITE)
            reg_addr <= reg_addr + 15'h0001;
      end
   end

   // ----------------------------------------
   // Readback shifter
   // ----------------------------------------
   logic tx_oe_reg;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tx_reg <= cfg_port_pkg::REG_RESET;
         tx_loaded_reg <= 1'b0;
         load_pending_reg <= 1'b0;
      end else begin
         load_pending_reg <= rd_strobe;
         if (load_pending_reg) begin
            tx_reg <= rd_data;
            tx_loaded_reg <= 1'b1;
         end else if (sclk_fall && phase_reg == ST_READ && tx_loaded_reg && bit_cnt_reg != 5'h00) begin
            tx_reg <= lsb_first ? {1'b0, tx_reg[7:1]} : {tx_reg[6:0], 1'b0};
         end
         if (phase_reg != ST_READ)
            tx_loaded_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         tx_oe_reg <= 1'b0;
      else
         tx_oe_reg <= cs_low && phase_reg == ST_READ && tx_loaded_reg;
   end

   // Select high releases the pin; frame survives byte-boundary stalls
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         port_idle <= 1'b1;
      else
         port_idle <= ~cs_low;
   end

   assign link.sdio_dev_oe = tx_oe_reg & cs_low;
   assign link.sdio_dev_o = lsb_first ? tx_reg[0] : tx_reg[7];
endmodule

// ===== rtl/cfg_port_host.sv
// Host end: makes shift clock by division, drives select and data, collects readback.
// Assumes the user issues one request at a time and drops it once busy rises, before done.
module cfg_port_host (
   input wire logic clock,
   input wire logic rst,
   cfg_port_if.host link,
   input wire logic req,
   input wire logic req_read,
   input wire logic [14:0] req_addr,
   input wire logic [7:0] req_wdata,
   input wire logic lsb_first,
   output logic busy,
   output logic done,
   output logic [7:0] rdata
);
   typedef enum {H_IDLE, H_LOW, H_HIGH, H_END} hstate_t;
   hstate_t state_reg;
   logic [3:0] div_reg;
   logic [4:0] bit_cnt_reg;
   logic [23:0] out_reg;
   logic [7:0] in_reg;
   logic read_reg;
   logic [1:0] sdio_sync_reg;
   logic [4:0] nbits;
   assign nbits = 5'h17;
   logic tick;
   assign tick = div_reg == 4'(cfg_port_pkg::SCLK_HALF_CYCLES - 1);

   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         sdio_sync_reg <= 2'h0;
      else
         sdio_sync_reg <= {sdio_sync_reg[0], link.sdio};
   end

   function automatic logic [7:0] rev8(input logic [7:0] v);
      for (int i = 0; i < 8; i++)
         rev8[i] = v[7 - i];
   endfunction

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg <= H_IDLE;
         div_reg <= 4'h0;
         bit_cnt_reg <= 5'h00;
         out_reg <= 24'h000000;
         in_reg <= 8'h00;
         read_reg <= 1'b0;
         done <= 1'b0;
         rdata <= 8'h00;
      end else begin
         done <= 1'b0;
         div_reg <= (state_reg == H_IDLE || tick) ? 4'h0 : div_reg + 4'h1;
         unique case (state_reg)
            H_IDLE: if (req) begin
               read_reg <= req_read;
               out_reg <= lsb_first ? {rev8(req_addr[7:0]), rev8({req_read, req_addr[14:8]}), rev8(req_wdata)}
                  : {req_read, req_addr, req_wdata};
               bit_cnt_reg <= 5'h00;
               state_reg <= H_LOW;
            end
            H_LOW: if (tick)
               state_reg <= H_HIGH;
            H_HIGH: if (tick) begin
               in_reg <= lsb_first ? {sdio_sync_reg[1], in_reg[7:1]} : {in_reg[6:0], sdio_sync_reg[1]};
               out_reg <= {out_reg[22:0], 1'b0};
               bit_cnt_reg <= bit_cnt_reg + 5'h01;
               state_reg <= (bit_cnt_reg == nbits) ? H_END : H_LOW;
            end
            H_END: if (tick) begin
               rdata <= in_reg;
               done <= 1'b1;
               state_reg <= H_IDLE;
            end
         endcase
      end
   end

   assign link.sclk = state_reg == H_HIGH;
   assign link.chip_select_n = state_reg == H_IDLE;
   assign link.sdio_host_o = out_reg[23];
   assign link.sdio_host_oe = (state_reg == H_LOW || state_reg == H_HIGH) && !(read_reg && bit_cnt_reg >= 5'h10);
   assign busy = state_reg != H_IDLE;
endmodule

// ===== dv/cfg_port_props.sv
// Checker for the three-wire link between the host end and the device end.
// Assumes it sits beside the interface and sees its signals on the system clock.
module cfg_port_props (
   input wire logic clock,
   input wire logic rst,
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic sdio_host_o,
   input wire logic sdio_host_oe,
   input wire logic sdio_dev_o,
   input wire logic sdio_dev_oe
);
   logic sclk_q;
   logic [5:0] rise_cnt;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // Shift clock rises within the open frame
   // ----------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= sclk;
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rise_cnt <= 6'h00;
      end else if (chip_select_n) begin
         rise_cnt <= 6'h00;
      end else if (sclk && !sclk_q) begin
         rise_cnt <= rise_cnt + 6'h01;
      end
   end
   sequence high_phase;
      sclk[*4];
   endsequence
   sequence low_phase;
      !sclk[*4];
   endsequence
   // Device release follows the select through its two-stage synchroniser
   sel_gates_dev_a: assert property (sdio_dev_oe |-> !$past(chip_select_n, 2))
      else $error("device drives data while deselected");
   no_contention_a: assert property (!(sdio_host_oe && sdio_dev_oe)) else $error("both ends drive data");
   sclk_idle_a: assert property (chip_select_n && $past(chip_select_n) |-> $stable(sclk)) else $error("sclk moves while idle");
   sclk_high_a: assert property ($rose(sclk) |-> high_phase) else $error("sclk high phase wrong");
   sclk_low_a: assert property ($fell(sclk) |-> low_phase) else $error("sclk low phase wrong");
   dev_change_a: assert property (sdio_dev_oe && $past(sdio_dev_oe) && $changed(sdio_dev_o) |-> !sclk)
      else $error("device data changes while sclk high");
   host_hold_a: assert property (sdio_host_oe && $past(sdio_host_oe) && sclk && $past(sclk) |-> $stable(sdio_host_o))
      else $error("host data changes while sclk high");
   frame_len_a: assert property ($rose(chip_select_n) |-> rise_cnt == 6'h18) else $error("frame not 24 bits");
   turn_point_a: assert property ($rose(sdio_dev_oe) |-> rise_cnt == 6'h10) else $error("turnaround at wrong bit");
   dev_hold_a: assert property ($rose(sdio_dev_oe) |-> sdio_dev_oe[*8]) else $error("readback drive too short");
endmodule

// ===== dv/adc_config_serial_port_tb.sv
// Bench joining host and device ends over one link; a small store answers device reads.
// Assumes both ends share the system clock and the same bit order setting.
module adc_config_serial_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic req = 1'b0;
   logic req_read = 1'b0;
   logic [14:0] req_addr = 15'h0000;
   logic [7:0] req_wdata = 8'h00;
   logic lsb_first = 1'b0;
   logic busy, done, wr_strobe, rd_strobe, port_idle, sdio_last = 1'b0;
   logic [7:0] rdata, wr_data, rd_data = 8'h00;
   logic [14:0] reg_addr;
   logic [7:0] mem [0:15];
   int n_mismatch = 0;
   int total_checks = 0;
   cfg_port_if link_if ();
   // ----------------------------------------
   // Shared data wire and register store
   // ----------------------------------------
   assign link_if.sdio = link_if.sdio_host_oe ? link_if.sdio_host_o :
                         link_if.sdio_dev_oe ? link_if.sdio_dev_o : ~sdio_last;
   always @(posedge clock) begin
      sdio_last <= link_if.sdio;
      if (wr_strobe) mem[reg_addr[3:0]] <= wr_data;
      rd_data <= mem[reg_addr[3:0]];
   end
   initial begin
      forever #25 clock = ~clock;
   end
   cfg_port_host cfg_port_host_inst (.clock(clock), .rst(rst), .link(link_if), .req(req), .req_read(req_read),
      .req_addr(req_addr), .req_wdata(req_wdata), .lsb_first(lsb_first), .busy(busy), .done(done), .rdata(rdata));
   cfg_port_device cfg_port_device_inst (.clock(clock), .rst(rst), .link(link_if), .lsb_first(lsb_first),
      .reg_addr(reg_addr), .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_data(rd_data), .rd_strobe(rd_strobe),
      .port_idle(port_idle));
   cfg_port_props cfg_port_props_inst (.clock(clock), .rst(rst), .sclk(link_if.sclk),
      .chip_select_n(link_if.chip_select_n), .sdio_host_o(link_if.sdio_host_o), .sdio_host_oe(link_if.sdio_host_oe),
      .sdio_dev_o(link_if.sdio_dev_o), .sdio_dev_oe(link_if.sdio_dev_oe));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic end_sim();
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [14:0] seen, input logic [14:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One frame; request dropped once taken so it is not reissued
   task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] d);
      int i;
      req <= 1'b1;
      req_read <= rd;
      req_addr <= a;
      req_wdata <= d;
      i = 0;
      do begin @(negedge clock); i++; end while (busy !== 1'b1 && i < 50);
      if (i >= 50) begin n_mismatch++; end_sim(); end
      @(posedge clock);
      req <= 1'b0;
      do begin @(negedge clock); i++; end while (done !== 1'b1 && i < 3000);
      if (i >= 3000) begin n_mismatch++; end_sim(); end
      repeat (8) @(negedge clock);
      chk("port_idle", {14'h0000, port_idle}, 15'h0001);
      @(posedge clock);
   endtask
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      xfer(1'b0, a, d);
      chk("reg_addr", reg_addr, a + 15'h0001);
      chk("wr_data", {7'h00, wr_data}, {7'h00, d});
   endtask
   task automatic rd(input logic [14:0] a, input logic [7:0] exp);
      xfer(1'b1, a, 8'h00);
      chk("reg_addr", reg_addr, a + 15'h0001);
      chk("rdata", {7'h00, rdata}, {7'h00, exp});
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      wr(15'h0003, 8'hA5);
      wr(15'h7FFF, 8'h3C);
      rd(15'h0003, 8'hA5);
      rd(15'h7FFF, 8'h3C);
      lsb_first <= 1'b1;
      @(posedge clock);
      wr(15'h4005, 8'h1E);
      rd(15'h4005, 8'h1E);
      rd(15'h0003, 8'hA5);
      end_sim();
   end
endmodule
